/* File: src/sdi_pkg.sv */
package sdi_pkg;
    // Timing
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned BASE_TIME_MS = 1;
    localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S * BASE_TIME_MS;
    localparam int unsigned MS_CNT_W = 17;

    // Mode and time base encodings
    localparam logic [7:0] MODE_PULSE = 8'hFF;
    localparam logic [7:0] IDX_MS = 8'hFD;
    localparam logic [7:0] SUB_PULSE_DIR = 8'h00;
    localparam logic [7:0] SUB_DUAL = 8'h01;

    // Register byte offsets
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_NUM = 8'h04;
    localparam logic [7:0] OFS_DEN = 8'h08;
    localparam logic [7:0] OFS_SUBTYPE = 8'h0C;
    localparam logic [7:0] OFS_INTERP = 8'h10;
    localparam logic [7:0] OFS_SFE = 8'h14;
    localparam logic [7:0] OFS_INV = 8'h18;
    localparam logic [7:0] OFS_FE_WIN = 8'h1C;
    localparam logic [7:0] OFS_FE_TMO = 8'h20;
    localparam logic [7:0] OFS_CTRL = 8'h24;
    localparam logic [7:0] OFS_POLES = 8'h28;
    localparam logic [7:0] OFS_OUT_IMG = 8'h2C;
    localparam logic [7:0] OFS_IN_IMG = 8'h30;
    localparam logic [7:0] OFS_DEMAND = 8'h34;
    localparam logic [7:0] OFS_STATUS = 8'h38;
    localparam logic [7:0] OFS_REV = 8'h3C;

    // Reset values
    localparam logic [15:0] RST_NUM = 16'h0080;
    localparam logic [15:0] RST_DEN = 16'h0001;
    localparam logic [7:0] RST_PERIOD = 8'h01;
    localparam logic [15:0] RST_POLES = 16'h0032;

    // Field positions and sizes
    localparam int unsigned N_IN = 5;
    localparam int unsigned N_OUT = 2;
    localparam int unsigned LVL_BASE = 16;
    localparam int unsigned N_SF = 3;
    localparam int unsigned FE_BIT = 13;
    localparam int unsigned IDX_LSB = 8;
    localparam int unsigned PIN_CLK = 0;
    localparam int unsigned PIN_DIR = 1;
    localparam logic [15:0] FULL_STEPS_PER_POLE = 16'h0004;

    typedef struct packed {
        logic [7:0] mode;
        logic [15:0] num;
        logic [15:0] den;
        logic [7:0] subtype;
        logic [7:0] period;
        logic [7:0] index;
        logic [N_SF-1:0] sfe;
        logic [N_IN-1:0] inv;
        logic [31:0] fe_win;
        logic [15:0] fe_tmo;
        logic closed_loop;
        logic [15:0] poles;
        logic [31:0] out_img;
    } sdi_cfg_t;
endpackage

/* File: src/sdi_top.sv */
`timescale 1ns/1ps
// Behaviour
// (R1) Pulse operation runs only while the mode register holds 0xFF.
// (R2) Each accepted clock pulse moves demand one scaled step in its sense.
// (R3) Source limits pulse rate to 1 MHz, active phase at least 200 ns.
// (R4) Pulses are buffered per cycle; demand is updated once per cycle.
// (R5) Cycle length is period times ten to the index; only 1 ms base.
// (R6) Increment per pulse is numerator divided by denominator.
// (R7) Reset numerator 128, denominator 1: quarter step; full 512, half 256.
// (R8) Brushless motor: one revolution is four times pole pairs in full steps.
// (R9) Source waits at least 35 us after a direction change before clocking.
// (R10) Closed loop: status bit 13 set when outside window beyond timeout.
// (R11) Subtype 0: pulses on clock input, sense from direction input level.
// (R12) Subtype 1: input 1 pulses go forward, input 2 pulses go reverse.
// (R13) General inputs sampled every 1 ms; shorter level changes are ignored.
// (R14) Special-function bits sit in image bits 0 to 15.
// (R15) Channel n level sits at image bit 15 plus n.
// (R16) Input image bit 16 always shows input 1 level.
// (R17) Input 1 limit or clock, 2 limit or direction, 3 home, 4 and 5 plain.
// (R18) Enable bit 0 activates negative limit, reported in image bit 0.
// (R19) Inversion bit n-1 selects normally closed logic for input n.
// (R20) Count on synchronised rising edge, direction sampled at that edge.
// (R21) Accumulator clears on transfer; a pulse in that cycle counts next.
module sdi_top #(
    parameter int unsigned MS_CYCLES = sdi_pkg::MS_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Digital input pins, asynchronous
    input wire logic [sdi_pkg::N_IN-1:0] din_pin,
    // Actual position from the position loop
    input wire logic [31:0] actual_pos,
    // Results
    output logic [31:0] demand_pos,
    output logic following_error,
    output logic [sdi_pkg::N_OUT-1:0] dout_pin
);
    sdi_pkg::sdi_cfg_t cfg_q, cfg_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic wr_pend_q, wr_pend_d;
    logic [7:0] wr_addr_q, wr_addr_d;
    logic [31:0] in_img_q, in_img_d;
    logic [31:0] demand_q, demand_d;
    logic [31:0] status_q, status_d;
    logic [sdi_pkg::N_OUT-1:0] dout_q, dout_d;

    logic [sdi_pkg::N_IN-1:0] meta_q, sync_q, prev_q;
    logic [sdi_pkg::N_IN-1:0] samp_q, samp_d, filt_q, filt_d;

    logic [sdi_pkg::MS_CNT_W-1:0] ms_cnt_q, ms_cnt_d;
    logic ms_tick_q, ms_tick_d;
    logic [7:0] per_cnt_q, per_cnt_d;
    logic signed [15:0] pcnt_q, pcnt_d;
    logic signed [31:0] rem_q, rem_d;
    logic [15:0] fe_cnt_q, fe_cnt_d;

    logic addr_ok;
    logic pulse_on;
    logic cyc_tick;
    logic signed [15:0] delta;
    logic signed [31:0] prod, sum, quot, den_s;
    logic [31:0] dev, dev_abs;
    logic [31:0] rev_steps;

    localparam logic [sdi_pkg::MS_CNT_W-1:0] MS_LAST =
        sdi_pkg::MS_CNT_W'(MS_CYCLES - 1);

    function automatic logic [31:0] rd_mux(input logic [7:0] a,
        input sdi_pkg::sdi_cfg_t c, input logic [31:0] img,
        input logic [31:0] dem, input logic [31:0] st,
        input logic [31:0] rev);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (a)
            sdi_pkg::OFS_MODE: r = {24'h000000, c.mode};
            sdi_pkg::OFS_NUM: r = {16'h0000, c.num};
            sdi_pkg::OFS_DEN: r = {16'h0000, c.den};
            sdi_pkg::OFS_SUBTYPE: r = {24'h000000, c.subtype};
            sdi_pkg::OFS_INTERP: r = {16'h0000, c.index, c.period};
            sdi_pkg::OFS_SFE: r = 32'(c.sfe);
            sdi_pkg::OFS_INV: r = 32'(c.inv);
            sdi_pkg::OFS_FE_WIN: r = c.fe_win;
            sdi_pkg::OFS_FE_TMO: r = {16'h0000, c.fe_tmo};
            sdi_pkg::OFS_CTRL: r = {31'h00000000, c.closed_loop};
            sdi_pkg::OFS_POLES: r = {16'h0000, c.poles};
            sdi_pkg::OFS_OUT_IMG: r = c.out_img;
            sdi_pkg::OFS_IN_IMG: r = img;
            sdi_pkg::OFS_DEMAND: r = dem;
            sdi_pkg::OFS_STATUS: r = st;
            sdi_pkg::OFS_REV: r = rev;
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    // Register bus: zero wait states, read data prepared at the address edge
    always_comb
    begin
        addr_ok = hsel && hready && htrans[1];
        cfg_d = cfg_q;
        hrdata_d = hrdata_q;
        wr_pend_d = addr_ok && hwrite;
        wr_addr_d = addr_ok ? haddr[7:0] : wr_addr_q;
        rev_steps = {16'h0000, cfg_q.poles} *
            {16'h0000, sdi_pkg::FULL_STEPS_PER_POLE}; // [R8]
        if (addr_ok && !hwrite)
        begin
            hrdata_d = rd_mux(haddr[7:0], cfg_q, in_img_q, demand_q,
                status_q, rev_steps);
        end
        if (wr_pend_q)
        begin
            case (wr_addr_q)
                sdi_pkg::OFS_MODE: cfg_d.mode = hwdata[7:0];
                sdi_pkg::OFS_NUM: cfg_d.num = hwdata[15:0];
                sdi_pkg::OFS_DEN: cfg_d.den = hwdata[15:0];
                sdi_pkg::OFS_SUBTYPE: cfg_d.subtype = hwdata[7:0];
                sdi_pkg::OFS_INTERP:
                begin
                    cfg_d.period = hwdata[7:0];
                    cfg_d.index = hwdata[15:8];
                end
                sdi_pkg::OFS_SFE: cfg_d.sfe = hwdata[sdi_pkg::N_SF-1:0];
                sdi_pkg::OFS_INV: cfg_d.inv = hwdata[sdi_pkg::N_IN-1:0];
                sdi_pkg::OFS_FE_WIN: cfg_d.fe_win = hwdata;
                sdi_pkg::OFS_FE_TMO: cfg_d.fe_tmo = hwdata[15:0];
                sdi_pkg::OFS_CTRL: cfg_d.closed_loop = hwdata[0];
                sdi_pkg::OFS_POLES: cfg_d.poles = hwdata[15:0];
                sdi_pkg::OFS_OUT_IMG: cfg_d.out_img = hwdata;
                default: cfg_d = cfg_q;
            endcase
        end
        dout_d = cfg_q.out_img[sdi_pkg::LVL_BASE +: sdi_pkg::N_OUT]; // [R15]
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            cfg_q <= '0;
            cfg_q.num <= sdi_pkg::RST_NUM; // [R7]
            cfg_q.den <= sdi_pkg::RST_DEN; // [R7]
            cfg_q.subtype <= sdi_pkg::SUB_PULSE_DIR; // [R11]
            cfg_q.period <= sdi_pkg::RST_PERIOD;
            cfg_q.index <= sdi_pkg::IDX_MS;
            cfg_q.poles <= sdi_pkg::RST_POLES;
            hrdata_q <= 32'h0000_0000;
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            dout_q <= '0;
        end
        else
        begin
            cfg_q <= cfg_d;
            hrdata_q <= hrdata_d;
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            dout_q <= dout_d;
        end
    end

    // Pins pass two flops; logic reads the second stage and a third delay flop
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end
        else
        begin
            meta_q <= din_pin;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // 1 ms base tick and interpolation cycle tick
    always_comb
    begin
        ms_tick_d = (ms_cnt_q == MS_LAST);
        ms_cnt_d = ms_tick_d ? '0 : ms_cnt_q + 1'b1;
        per_cnt_d = per_cnt_q;
        cyc_tick = 1'b0;
        // Only the 1 ms index is honoured; a zero period acts as one
        if (ms_tick_q)
        begin
            if (per_cnt_q + 8'h01 >= cfg_q.period) // [R5]
            begin
                per_cnt_d = 8'h00;
                cyc_tick = 1'b1;
            end
            else
            begin
                per_cnt_d = per_cnt_q + 8'h01;
            end
        end
    end

    // Pulse capture, per-cycle buffer and scaled demand update
    always_comb
    begin
        pulse_on = (cfg_q.mode == sdi_pkg::MODE_PULSE); // [R1]
        delta = 16'sd0;
        if (cfg_q.subtype == sdi_pkg::SUB_DUAL)
        begin
            // Simultaneous pulses on both inputs cancel out
            if (sync_q[sdi_pkg::PIN_CLK] && !prev_q[sdi_pkg::PIN_CLK])
                delta = delta + 16'sd1; // [R12]
            if (sync_q[sdi_pkg::PIN_DIR] && !prev_q[sdi_pkg::PIN_DIR])
                delta = delta - 16'sd1; // [R12]
        end
        else if (sync_q[sdi_pkg::PIN_CLK] && !prev_q[sdi_pkg::PIN_CLK])
        begin
            delta = sync_q[sdi_pkg::PIN_DIR] ? 16'sd1 : -16'sd1; // [R11] [R20]
        end
        if (!pulse_on)
            delta = 16'sd0;
        den_s = (cfg_q.den == 16'h0000) ? 32'sd1 :
            $signed({16'h0000, cfg_q.den});
        prod = 32'(pcnt_q) * $signed({16'h0000, cfg_q.num}); // [R6]
        sum = rem_q + prod;
        quot = sum / den_s; // [R6]
        demand_d = demand_q;
        rem_d = rem_q;
        pcnt_d = pcnt_q + delta; // [R4]
        if (!pulse_on)
        begin
            pcnt_d = 16'sd0;
            rem_d = 32'sd0;
        end
        else if (cyc_tick)
        begin
            // Remainder carried so fractional steps are not lost
            demand_d = demand_q + quot; // [R2] [R4]
            rem_d = sum - quot * den_s;
            pcnt_d = delta; // [R21]
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            ms_cnt_q <= '0;
            ms_tick_q <= 1'b0;
            per_cnt_q <= 8'h00;
            pcnt_q <= 16'sd0;
            rem_q <= 32'sd0;
            demand_q <= 32'h0000_0000;
        end
        else
        begin
            ms_cnt_q <= ms_cnt_d;
            ms_tick_q <= ms_tick_d;
            per_cnt_q <= per_cnt_d;
            pcnt_q <= pcnt_d;
            rem_q <= rem_d;
            demand_q <= demand_d;
        end
    end

    // Digital input image and following error
    always_comb
    begin
        samp_d = samp_q;
        filt_d = filt_q;
        if (ms_tick_q)
        begin
            samp_d = sync_q; // [R13]
            // A level is taken only when two 1 ms samples agree
            filt_d = (sync_q ~^ samp_q) & sync_q |
                (sync_q ^ samp_q) & filt_q; // [R13]
        end
        in_img_d = 32'h0000_0000;
        in_img_d[sdi_pkg::LVL_BASE +: sdi_pkg::N_IN] =
            filt_q ^ cfg_q.inv; // [R15] [R16] [R19]
        // Limit and home flags, inputs 1 to 3 in bits 0 to 2
        in_img_d[sdi_pkg::N_SF-1:0] = cfg_q.sfe &
            (filt_q[sdi_pkg::N_SF-1:0] ^ cfg_q.inv[sdi_pkg::N_SF-1:0]);
            // [R14] [R17] [R18]
        dev = demand_q - actual_pos;
        dev_abs = dev[31] ? (32'h0000_0000 - dev) : dev;
        fe_cnt_d = fe_cnt_q;
        if (!cfg_q.closed_loop || dev_abs <= cfg_q.fe_win)
            fe_cnt_d = 16'h0000;
        else if (ms_tick_q && fe_cnt_q != 16'hFFFF)
            fe_cnt_d = fe_cnt_q + 16'h0001;
        status_d = 32'h0000_0000;
        status_d[sdi_pkg::FE_BIT] = cfg_q.closed_loop &&
            dev_abs > cfg_q.fe_win && fe_cnt_q > cfg_q.fe_tmo; // [R10]
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            samp_q <= '0;
            filt_q <= '0;
            in_img_q <= 32'h0000_0000;
            fe_cnt_q <= 16'h0000;
            status_q <= 32'h0000_0000;
        end
        else
        begin
            samp_q <= samp_d;
            filt_q <= filt_d;
            in_img_q <= in_img_d;
            fe_cnt_q <= fe_cnt_d;
            status_q <= status_d;
        end
    end

    // Constant answers still come from flops, the same in and out of reset
    always_ff @(posedge core_clk)
    begin
        hreadyout <= 1'b1;
        hresp <= 1'b0;
    end

    assign hrdata = hrdata_q;
    assign demand_pos = demand_q;
    assign following_error = status_q[sdi_pkg::FE_BIT];
    assign dout_pin = dout_q;
endmodule

/* File: sim/sdi_chk_sva.sv */
`timescale 1ns/1ps
module sdi_chk (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Motion
    input wire logic [31:0] actual_pos,
    input wire logic [31:0] demand_pos,
    input wire logic following_error,
    input wire logic [1:0] dout_pin
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    // Cycles since demand and actual last differed
    logic [3:0] age_d;
    logic [3:0] age_q;
    always_comb
    begin
        age_d = (age_q == 4'hF) ? age_q : age_q + 4'h1;
        if (demand_pos != actual_pos)
            age_d = 4'h0;
    end
    always_ff @(posedge core_clk)
        if (!rst_b)
            age_q <= 4'hF;
        else
            age_q <= age_d;
    sequence s_rd(logic [7:0] a);
        hsel && hready && htrans[1] && !hwrite && haddr[7:0] == a;
    endsequence
    property p_out;
        logic [1:0] d;
        (hsel && hready && htrans[1] && hwrite
            && haddr[7:0] == sdi_pkg::OFS_OUT_IMG)
        ##1 (1'b1, d = hwdata[17:16]) |-> ##[1:2] dout_pin == d;
    endproperty
    AST_DEMAND_ONCE_PER_CYCLE:
    assert property ($changed(demand_pos) |=> $stable(demand_pos)[*8])
        else $error("demand moved twice within one cycle");
    AST_DEMAND_RESET_ZERO:
    assert property ($rose(rst_b) |-> demand_pos == 32'h0)
        else $error("demand not zero after reset");
    AST_DEMAND_READBACK:
    assert property (s_rd(sdi_pkg::OFS_DEMAND) |=> hrdata == $past(demand_pos))
        else $error("demand readback differs");
    AST_STATUS_BIT13:
    assert property (s_rd(sdi_pkg::OFS_STATUS)
        |=> hrdata == {18'h0, $past(following_error), 13'h0})
        else $error("status word differs from error flag");
    AST_FE_CAUSE:
    assert property ($rose(following_error) |-> age_q < 4'h4)
        else $error("following error without deviation");
    AST_FE_RESET_LOW:
    assert property ($rose(rst_b) |-> !following_error)
        else $error("following error set after reset");
    AST_OUT_LEVEL:
    assert property (p_out)
        else $error("output pins differ from image bits");
    AST_ZERO_WAIT_OKAY:
    assert property (hreadyout && !hresp)
        else $error("wait state or error response");
    cover property ($changed(demand_pos));
    cover property ($rose(following_error));
    cover property ($changed(dout_pin));
endmodule

/* File: sim/sdi_pulse_src.sv */
`timescale 1ns/1ps
module sdi_pulse_src #(
    parameter int HIGH_CYC = 25,
    parameter int LOW_CYC = 100,
    parameter int DIR_SETUP = 4375
) (
    // Clock
    input wire logic core_clk,
    // Inputs 1 and 2
    output logic [1:0] pulse_pins
);
    initial pulse_pins = 2'b00;
    // Pin 0 pulses with pin 1 as sense; pin 1 alone pulses reverse
    task automatic send(input int pin, input logic dir, input int n);
        logic [1:0] idle;
        idle = (pin == 0) ? {dir, 1'b0} : 2'b00;
        if (idle != pulse_pins)
        begin
            @(posedge core_clk);
            pulse_pins <= idle;
            repeat (DIR_SETUP) @(posedge core_clk);
        end
        repeat (n)
        begin
            @(posedge core_clk);
            pulse_pins[pin] <= 1'b1;
            repeat (HIGH_CYC) @(posedge core_clk);
            pulse_pins[pin] <= 1'b0;
            repeat (LOW_CYC) @(posedge core_clk);
        end
    endtask
endmodule

/* File: sim/step_direction_input_unit_test.sv */
`timescale 1ns/1ps
module step_direction_input_unit_test;
    // Short millisecond keeps the run small
    localparam int MS = 500;
    logic core_clk, rst_b, hsel, hwrite, hready, hresp, following_error;
    logic [31:0] haddr, hwdata, hrdata, actual_pos, demand_pos, v;
    logic [1:0] htrans, pulse_pins, dout_pin;
    logic [2:0] hsize, din_hi;
    int n_errors, tests_run;
    sdi_top #(.MS_CYCLES(MS)) dut (.core_clk(core_clk), .rst_b(rst_b),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .din_pin({din_hi, pulse_pins}), .actual_pos(actual_pos),
        .demand_pos(demand_pos), .following_error(following_error),
        .dout_pin(dout_pin));
    sdi_pulse_src src (.core_clk(core_clk), .pulse_pins(pulse_pins));
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task summarize;
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task wait_rdy;
        int i;
        i = 0;
        do
        begin
            @(posedge core_clk);
            i++;
        end
        while (hready !== 1'b1 && i < 50);
        if (i >= 50)
        begin
            n_errors++;
            summarize;
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        wait_rdy;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy;
        v = hrdata;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(v, exp);
    endtask
    task settle(input logic [31:0] exp);
        cyc(2 * MS + 10);
        chk(demand_pos, exp);
    endtask
    task t_regs;
        rdchk(sdi_pkg::OFS_MODE, 32'h0);
        rdchk(sdi_pkg::OFS_NUM, 32'h80);
        rdchk(sdi_pkg::OFS_DEN, 32'h1);
        rdchk(sdi_pkg::OFS_SUBTYPE, 32'h0);
        rdchk(sdi_pkg::OFS_INTERP, 32'hFD01);
        rdchk(8'h40, 32'h0);
        wr(sdi_pkg::OFS_REV, 32'h5);
        rdchk(sdi_pkg::OFS_REV, 32'hC8);
        wr(sdi_pkg::OFS_POLES, 32'h3);
        rdchk(sdi_pkg::OFS_REV, 32'hC);
    endtask
    task t_steps;
        src.send(0, 1'b1, 3);
        settle(32'h0);
        wr(sdi_pkg::OFS_MODE, 32'hFF);
        src.send(0, 1'b1, 3);
        settle(32'h180);
        wr(sdi_pkg::OFS_NUM, 32'h200);
        wr(sdi_pkg::OFS_DEN, 32'h2);
        src.send(0, 1'b0, 5);
        settle(32'hFFFFFC80);
        wr(sdi_pkg::OFS_NUM, 32'h1);
        wr(sdi_pkg::OFS_DEN, 32'h3);
        src.send(0, 1'b1, 3);
        settle(32'hFFFFFC81);
    endtask
    task t_dual;
        wr(sdi_pkg::OFS_NUM, 32'h80);
        wr(sdi_pkg::OFS_DEN, 32'h1);
        wr(sdi_pkg::OFS_SUBTYPE, 32'h1);
        src.send(0, 1'b0, 2);
        settle(32'hFFFFFD81);
        src.send(1, 1'b0, 1);
        settle(32'hFFFFFD01);
    endtask
    task t_period;
        int i;
        logic [31:0] last;
        wr(sdi_pkg::OFS_INTERP, 32'h0000FD02);
        fork
            src.send(0, 1'b0, 24);
            begin
                i = 0;
                last = demand_pos;
                while (demand_pos === last && i < 3 * MS)
                begin
                    @(posedge core_clk);
                    i++;
                end
                last = demand_pos;
                i = 0;
                while (demand_pos === last && i < 3 * MS)
                begin
                    @(posedge core_clk);
                    i++;
                end
                chk(i, 2 * MS);
            end
        join
        rdchk(sdi_pkg::OFS_INTERP, 32'hFD02);
        wr(sdi_pkg::OFS_INTERP, 32'h0000FD01);
        settle(32'h00000901);
    endtask
    task t_inputs;
        wr(sdi_pkg::OFS_MODE, 32'h0);
        din_hi <= 3'b101;
        cyc(3 * MS);
        rdchk(sdi_pkg::OFS_IN_IMG, 32'h00140000);
        wr(sdi_pkg::OFS_SFE, 32'h7);
        wr(sdi_pkg::OFS_INV, 32'h1);
        cyc(3 * MS);
        rdchk(sdi_pkg::OFS_IN_IMG, 32'h00150005);
        // Glitch shorter than one tick spacing, polled during and after
        din_hi <= 3'b111;
        repeat (MS / 3) rdchk(sdi_pkg::OFS_IN_IMG, 32'h00150005);
        din_hi <= 3'b101;
        repeat (MS / 3) rdchk(sdi_pkg::OFS_IN_IMG, 32'h00150005);
        cyc(2 * MS);
        rdchk(sdi_pkg::OFS_IN_IMG, 32'h00150005);
    endtask
    task t_out_fe;
        wr(sdi_pkg::OFS_OUT_IMG, 32'h00020000);
        cyc(3);
        chk({30'h0, dout_pin}, 32'h2);
        wr(sdi_pkg::OFS_OUT_IMG, 32'h00010000);
        cyc(3);
        chk({30'h0, dout_pin}, 32'h1);
        @(posedge core_clk);
        actual_pos <= demand_pos + 32'd100;
        wr(sdi_pkg::OFS_FE_WIN, 32'd10);
        wr(sdi_pkg::OFS_FE_TMO, 32'd2);
        wr(sdi_pkg::OFS_CTRL, 32'h1);
        // At most one tick has passed, still inside the timeout
        cyc(MS);
        chk({31'h0, following_error}, 32'h0);
        cyc(4 * MS);
        chk({31'h0, following_error}, 32'h1);
        rdchk(sdi_pkg::OFS_STATUS, 32'h2000);
        actual_pos <= demand_pos;
        cyc(3 * MS);
        chk({31'h0, following_error}, 32'h0);
    endtask
    initial
    begin
        rst_b = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        din_hi = 3'h0;
        actual_pos = 32'h0;
        n_errors = 0;
        tests_run = 0;
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        t_regs;
        t_steps;
        t_dual;
        t_period;
        t_inputs;
        t_out_fe;
        summarize;
    end
    initial
    begin
        #800000;
        n_errors++;
        summarize;
    end
endmodule
bind sdi_top sdi_chk chk_i (.core_clk(core_clk), .rst_b(rst_b),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .actual_pos(actual_pos),
    .demand_pos(demand_pos), .following_error(following_error),
    .dout_pin(dout_pin));
